// [logic/nps_consts.svh]
// Purpose: shared constants of the parallel flash and psram bus ends
// Assumes: 100 MHz mclk
// Notes: times in ns, cycle counts derived from them
`ifndef NPS_CONSTS_SVH
`define NPS_CONSTS_SVH
`define NPS_ADDR_W 24
`define NPS_DATA_W 16
`define NPS_LANE_W 8
`define NPS_LANES 2
`define NPS_CNT_W 16
`define NPS_CLK_NS 10
`define NPS_ACCESS_NS 70
`define NPS_ACCESS_CYC ((`NPS_ACCESS_NS + `NPS_CLK_NS - 1) / `NPS_CLK_NS)
`define NPS_DPDX_NS 10000
`define NPS_DPDX_CYC ((`NPS_DPDX_NS + `NPS_CLK_NS - 1) / `NPS_CLK_NS)
`define NPS_CFG_SEL_BIT 19
`define NPS_IDENT_SEL_BIT 18
`define NPS_DPD_EN_BIT 4
`define NPS_REFRESH_CFG_RESET 16'h0010
`define NPS_BUS_CFG_RESET 16'h0000
// ident value is arbitrary
`define NPS_IDENT_VALUE 16'h5a5a
`define NPS_SCR_SETUP 8'h60
`define NPS_SCR_CONFIRM 8'h03
`define NPS_WAIT_POL_BIT 10
`endif

// [logic/nps_pkg.sv]
// Purpose: types shared by both bus ends
// Assumes: nothing
// Notes: binary state codes written out
package nps_pkg;
    typedef enum logic [3:0] {
        op_flash_read = 4'h0,
        op_flash_write = 4'h1,
        op_flash_latch = 4'h2,
        op_psram_read = 4'h3,
        op_psram_write = 4'h4,
        op_cfg_read = 4'h5,
        op_cfg_write = 4'h6,
        op_psram_sleep = 4'h7,
        op_psram_wake = 4'h8
    } nps_op_t;
    typedef enum logic {
        fl_idle = 1'b0,
        fl_cfg_setup = 1'b1
    } nps_flash_cmd_t;
    typedef enum logic {
        pw_run = 1'b0,
        pw_deep = 1'b1
    } nps_power_t;
    typedef enum logic [2:0] {
        hs_idle = 3'b000,
        hs_setup = 3'b001,
        hs_strobe = 3'b010,
        hs_hold = 3'b011,
        hs_exit = 3'b100
    } nps_host_state_t;
endpackage

// [logic/nps_bus_if.sv]
// Purpose: shared parallel bus between host controller and the two dies
// Assumes: at most one driver per lane at a time
// Notes: undriven lanes read as zero, contention flags overlap
`timescale 1ns/1ns
`include "nps_consts.svh"
interface nps_bus_if;
    logic flash_reset_n;
    logic flash_ce_n;
    logic flash_oe_n;
    logic flash_we_n;
    logic psram_ce_n;
    logic psram_oe_n;
    logic psram_we_n;
    logic config_reg_select;
    logic upper_byte_enable_n;
    logic lower_byte_enable_n;
    logic address_latch_n;
    logic burst_clk;
    logic [`NPS_ADDR_W-1:0] addr;
    logic [`NPS_DATA_W-1:0] host_dq;
    logic host_dq_oe;
    logic [`NPS_DATA_W-1:0] flash_dq;
    logic flash_dq_oe;
    logic [`NPS_DATA_W-1:0] psram_dq;
    logic [`NPS_LANES-1:0] psram_dq_oe;
    logic wait_out;
    logic wait_oe;
    logic [`NPS_DATA_W-1:0] dq;
    logic [`NPS_LANES-1:0] contention;
    genvar g;
    for (g = 0; g < `NPS_LANES; g = g + 1) begin : lane
        assign dq[g*`NPS_LANE_W +: `NPS_LANE_W] =
            host_dq_oe ? host_dq[g*`NPS_LANE_W +: `NPS_LANE_W] :
            flash_dq_oe ? flash_dq[g*`NPS_LANE_W +: `NPS_LANE_W] :
            psram_dq_oe[g] ? psram_dq[g*`NPS_LANE_W +: `NPS_LANE_W] : 8'h00;
        assign contention[g] = (host_dq_oe & flash_dq_oe) | (host_dq_oe & psram_dq_oe[g]) |
            (flash_dq_oe & psram_dq_oe[g]);
    end
    modport dev (
        input flash_reset_n, flash_ce_n, flash_oe_n, flash_we_n,
        input psram_ce_n, psram_oe_n, psram_we_n, config_reg_select,
        input upper_byte_enable_n, lower_byte_enable_n, address_latch_n, burst_clk, addr, dq,
        output flash_dq, flash_dq_oe, psram_dq, psram_dq_oe, wait_out, wait_oe
    );
    modport host (
        output flash_reset_n, flash_ce_n, flash_oe_n, flash_we_n,
        output psram_ce_n, psram_oe_n, psram_we_n, config_reg_select,
        output upper_byte_enable_n, lower_byte_enable_n, address_latch_n, burst_clk, addr,
        output host_dq, host_dq_oe,
        input dq, wait_out, wait_oe
    );
endinterface

// [logic/nps_device.sv]
// Purpose: device end of the shared bus, flash and psram die decode
// Assumes: pins synchronous to mclk, array storage lives on the user side
// Notes: flash command set beyond the wait polarity setup stays outside
`timescale 1ns/1ns
`include "nps_consts.svh"
////////////////////////////////////////////////////////////////////////////////
module nps_device (
    input wire logic mclk,
    input wire logic rst_n,
    nps_bus_if.dev bus,
    input wire logic [`NPS_DATA_W-1:0] flash_rd_data,
    input wire logic flash_unlock_all,
    input wire logic [`NPS_DATA_W-1:0] psram_rd_data,
    output logic [`NPS_ADDR_W-1:0] flash_rd_addr,
    output logic flash_cmd_valid,
    output logic [`NPS_ADDR_W-1:0] flash_cmd_addr,
    output logic [`NPS_DATA_W-1:0] flash_cmd_data,
    output logic flash_locked,
    output logic flash_wait_polarity,
    output logic [`NPS_ADDR_W-1:0] psram_rd_addr,
    output logic psram_wr_valid,
    output logic [`NPS_ADDR_W-1:0] psram_wr_addr,
    output logic [`NPS_DATA_W-1:0] psram_wr_data,
    output logic [`NPS_LANES-1:0] psram_wr_strobe,
    output logic psram_active,
    output logic psram_deep_down,
    output logic [`NPS_DATA_W-1:0] bus_config_register,
    output logic [`NPS_DATA_W-1:0] refresh_config_register
);
    import nps_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    logic fl_sel;
    logic fl_rd;
    logic fl_wr;
    logic fl_wr_q;
    logic fl_rst;
    logic latch_hold;
    logic [`NPS_ADDR_W-1:0] latch_addr;
    logic [`NPS_ADDR_W-1:0] fl_wr_addr;
    logic [`NPS_DATA_W-1:0] fl_wr_data;
    nps_flash_cmd_t fl_cmd;
    logic ps_sel;
    logic ps_rd;
    logic ps_wr;
    logic ps_wr_q;
    logic ps_ce_q;
    logic [`NPS_ADDR_W-1:0] ps_wr_addr;
    logic [`NPS_DATA_W-1:0] ps_wr_data;
    logic [`NPS_LANES-1:0] ps_wr_lane_n;
    logic ps_wr_cfg;
    logic [`NPS_LANES-1:0] lane_n;
    logic [`NPS_DATA_W-1:0] cfg_rd_value;
    nps_power_t power;
    logic [`NPS_CNT_W-1:0] exit_cnt;

    assign fl_rst = ~bus.flash_reset_n;
    assign fl_sel = ~bus.flash_ce_n & bus.flash_reset_n;
    assign fl_rd = fl_sel & ~bus.flash_oe_n & bus.flash_we_n;
    assign fl_wr = fl_sel & ~bus.flash_we_n;
    // psram ignores every pin except psram_ce_n while deselected or powered down
    assign ps_sel = ~bus.psram_ce_n & (power == pw_run);
    assign ps_rd = ps_sel & ~bus.psram_oe_n & bus.psram_we_n;
    assign ps_wr = ps_sel & ~bus.psram_we_n;
    assign lane_n = {bus.upper_byte_enable_n, bus.lower_byte_enable_n};
    assign psram_active = ps_sel;
    assign psram_deep_down = (power == pw_deep);
    ////////////////////////////////////////////////////////////////////////////
    // flash read path, outputs released in reset
    assign bus.flash_dq_oe = fl_rd;
    assign bus.wait_oe = fl_sel;
    // async mode never stalls, so wait shows its idle level
    assign bus.wait_out = ~flash_wait_polarity;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latch_hold <= 1'b0;
            latch_addr <= '0;
        end else if (fl_rst | bus.flash_ce_n) begin
            latch_hold <= 1'b0;
        end else if (~bus.address_latch_n) begin
            latch_hold <= 1'b1;
            latch_addr <= bus.addr;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flash_rd_addr <= '0;
            bus.flash_dq <= '0;
        end else if (fl_rd) begin
            flash_rd_addr <= latch_hold ? latch_addr : bus.addr;
            bus.flash_dq <= flash_rd_data;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // flash write: address and data taken at the end of the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fl_wr_q <= 1'b0;
            fl_wr_addr <= '0;
            fl_wr_data <= '0;
        end else begin
            fl_wr_q <= fl_wr & ~fl_rst;
            if (fl_wr) begin
                fl_wr_addr <= bus.addr;
                fl_wr_data <= bus.dq;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cmd_valid <= 1'b0;
            flash_cmd_addr <= '0;
            flash_cmd_data <= '0;
        end else begin
            flash_cmd_valid <= fl_wr_q & ~fl_wr & ~fl_rst;
            if (fl_wr_q & ~fl_wr) begin
                flash_cmd_addr <= fl_wr_addr;
                flash_cmd_data <= fl_wr_data;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fl_cmd <= fl_idle;
            flash_wait_polarity <= 1'b0;
            flash_locked <= 1'b1;
        end else if (fl_rst) begin
            fl_cmd <= fl_idle;
            flash_wait_polarity <= 1'b0;
            flash_locked <= 1'b1;
        end else begin
            if (flash_unlock_all) begin
                flash_locked <= 1'b0;
            end
            if (fl_wr_q & ~fl_wr) begin
                case (fl_cmd)
                    fl_idle: begin
                        if (fl_wr_data[`NPS_LANE_W-1:0] == `NPS_SCR_SETUP) begin
                            fl_cmd <= fl_cfg_setup;
                        end
                    end
                    fl_cfg_setup: begin
                        if (fl_wr_data[`NPS_LANE_W-1:0] == `NPS_SCR_CONFIRM) begin
                            flash_wait_polarity <= fl_wr_addr[`NPS_WAIT_POL_BIT];
                        end
                        fl_cmd <= fl_idle;
                    end
                    default: fl_cmd <= fl_idle;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // psram read path
    always_comb begin
        if (bus.addr[`NPS_IDENT_SEL_BIT]) begin
            cfg_rd_value = `NPS_IDENT_VALUE;
        end else if (bus.addr[`NPS_CFG_SEL_BIT]) begin
            cfg_rd_value = bus_config_register;
        end else begin
            cfg_rd_value = refresh_config_register;
        end
    end

    genvar g;
    for (g = 0; g < `NPS_LANES; g = g + 1) begin : lane
        // read decode of chip enable, output enable, write enable and run power state is the only driver control, lane gated by its enable
        assign bus.psram_dq_oe[g] = ps_rd & ~lane_n[g];
        assign psram_wr_strobe[g] = ~ps_wr_lane_n[g];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            psram_rd_addr <= '0;
            bus.psram_dq <= '0;
        end else if (ps_rd) begin
            psram_rd_addr <= bus.addr;
            bus.psram_dq <= bus.config_reg_select ? cfg_rd_value : psram_rd_data;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // psram write capture
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ps_wr_q <= 1'b0;
            ps_wr_addr <= '0;
            ps_wr_data <= '0;
            ps_wr_lane_n <= {`NPS_LANES{1'b1}};
            ps_wr_cfg <= 1'b0;
        end else begin
            ps_wr_q <= ps_wr;
            if (ps_wr) begin
                ps_wr_addr <= bus.addr;
                ps_wr_data <= bus.dq;
                ps_wr_lane_n <= lane_n;
                ps_wr_cfg <= bus.config_reg_select;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            psram_wr_valid <= 1'b0;
            psram_wr_addr <= '0;
            psram_wr_data <= '0;
        end else begin
            psram_wr_valid <= ps_wr_q & ~ps_wr & ~ps_wr_cfg;
            if (ps_wr_q & ~ps_wr) begin
                psram_wr_addr <= ps_wr_addr;
                psram_wr_data <= ps_wr_data;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_config_register <= `NPS_BUS_CFG_RESET;
            refresh_config_register <= `NPS_REFRESH_CFG_RESET;
        end else if (ps_wr_q & ~ps_wr & ps_wr_cfg) begin
            // the ident register is read only, its writes vanish
            if (ps_wr_addr[`NPS_IDENT_SEL_BIT]) begin
                bus_config_register <= bus_config_register;
            end else if (ps_wr_addr[`NPS_CFG_SEL_BIT]) begin
                bus_config_register <= ps_wr_data;
            end else begin
                refresh_config_register <= ps_wr_data;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // deep power-down
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ps_ce_q <= 1'b1;
            power <= pw_run;
            exit_cnt <= '0;
        end else begin
            ps_ce_q <= bus.psram_ce_n;
            case (power)
                pw_run: begin
                    exit_cnt <= '0;
                    if (~ps_ce_q & bus.psram_ce_n & ~refresh_config_register[`NPS_DPD_EN_BIT]) begin
                        power <= pw_deep;
                    end
                end
                pw_deep: begin
                    // a short high pulse restarts the count
                    if (bus.psram_ce_n) begin
                        exit_cnt <= '0;
                    end else if (exit_cnt == `NPS_CNT_W'(`NPS_DPDX_CYC - 1)) begin
                        exit_cnt <= '0;
                        power <= pw_run;
                    end else begin
                        exit_cnt <= exit_cnt + `NPS_CNT_W'(1);
                    end
                end
                default: power <= pw_run;
            endcase
        end
    end
endmodule

// [logic/nps_host.sv]
// Purpose: host controller end of the shared bus
// Assumes: one request at a time, user waits for done
// Notes: strobes are combinational from registered state
`timescale 1ns/1ns
`include "nps_consts.svh"
module nps_host (
    input wire logic mclk,
    input wire logic rst_n,
    nps_bus_if.host bus,
    input wire logic req,
    input wire nps_pkg::nps_op_t req_op,
    input wire logic [`NPS_ADDR_W-1:0] req_addr,
    input wire logic [`NPS_DATA_W-1:0] req_data,
    input wire logic [`NPS_LANES-1:0] req_byte_n,
    output logic busy,
    output logic done,
    output logic [`NPS_DATA_W-1:0] rd_data
);
    import nps_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    nps_host_state_t state;
    nps_op_t op;
    logic [`NPS_ADDR_W-1:0] addr_q;
    logic [`NPS_DATA_W-1:0] data_q;
    logic [`NPS_LANES-1:0] byte_n_q;
    logic [`NPS_CNT_W-1:0] cnt;
    logic reset_done;
    logic active;
    logic strobe;
    logic is_flash;
    logic is_read;
    logic is_write;
    logic is_cfg;

    assign active = (state != hs_idle);
    assign strobe = (state == hs_strobe);
    assign is_flash = (op == op_flash_read) | (op == op_flash_write) | (op == op_flash_latch);
    assign is_read = (op == op_flash_read) | (op == op_psram_read) | (op == op_cfg_read);
    assign is_write = (op == op_flash_write) | (op == op_psram_write) | (op == op_cfg_write);
    assign is_cfg = (op == op_cfg_read) | (op == op_cfg_write);
    assign busy = active;
    ////////////////////////////////////////////////////////////////////////////
    // only one die selected at any time
    assign bus.flash_reset_n = reset_done;
    assign bus.flash_ce_n = ~(active & is_flash);
    assign bus.psram_ce_n = ~(active & ~is_flash);
    assign bus.flash_oe_n = ~(strobe & is_flash & is_read);
    assign bus.flash_we_n = ~(strobe & is_flash & is_write);
    assign bus.psram_oe_n = ~(strobe & ~is_flash & is_read);
    assign bus.psram_we_n = ~(strobe & ~is_flash & is_write);
    assign bus.address_latch_n = ~(strobe & (op == op_flash_latch));
    assign bus.config_reg_select = active & is_cfg;
    // config reads need both lanes, config writes ignore them
    assign bus.upper_byte_enable_n = ~active | is_flash | (op == op_cfg_read ? 1'b0 : byte_n_q[1]);
    assign bus.lower_byte_enable_n = ~active | is_flash | (op == op_cfg_read ? 1'b0 : byte_n_q[0]);
    assign bus.burst_clk = 1'b0;
    assign bus.addr = addr_q;
    assign bus.host_dq = data_q;
    // host drives data only for writes, released for reads
    assign bus.host_dq_oe = active & is_write & (state != hs_exit);
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reset_done <= 1'b0;
        end else begin
            reset_done <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= hs_idle;
            op <= op_flash_read;
            addr_q <= '0;
            data_q <= '0;
            byte_n_q <= {`NPS_LANES{1'b1}};
            cnt <= '0;
            done <= 1'b0;
            rd_data <= '0;
        end else begin
            done <= 1'b0;
            case (state)
                hs_idle: begin
                    if (req & reset_done) begin
                        op <= req_op;
                        addr_q <= req_addr;
                        data_q <= req_data;
                        byte_n_q <= req_byte_n;
                        cnt <= '0;
                        state <= (req_op == op_psram_wake) ? hs_exit : hs_setup;
                    end
                end
                hs_setup: begin
                    state <= (op == op_psram_sleep) ? hs_hold : hs_strobe;
                end
                hs_strobe: begin
                    if (cnt == `NPS_CNT_W'(`NPS_ACCESS_CYC - 1)) begin
                        cnt <= '0;
                        if (is_read) begin
                            rd_data <= bus.dq;
                        end
                        state <= hs_hold;
                    end else begin
                        cnt <= cnt + `NPS_CNT_W'(1);
                    end
                end
                hs_exit: begin
                    // one spare cycle beyond the exit time for margin
                    if (cnt == `NPS_CNT_W'(`NPS_DPDX_CYC)) begin
                        cnt <= '0;
                        state <= hs_hold;
                    end else begin
                        cnt <= cnt + `NPS_CNT_W'(1);
                    end
                end
                hs_hold: begin
                    done <= 1'b1;
                    state <= hs_idle;
                end
                default: state <= hs_idle;
            endcase
        end
    end
endmodule

// [sim/nps_props.sv]
// Purpose: rule checker on the shared flash/psram bus
// Assumes: one mclk domain, interface signals only
// Notes: strobe length of 7 cycles comes from the host access time
`timescale 1ns/1ns
module nps_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flash_reset_n,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic psram_ce_n,
    input wire logic psram_oe_n,
    input wire logic psram_we_n,
    input wire logic upper_byte_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic address_latch_n,
    input wire logic burst_clk,
    input wire logic flash_dq_oe,
    input wire logic [1:0] psram_dq_oe,
    input wire logic wait_oe,
    input wire logic [1:0] contention
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    sequence flash_read_s;
        (!flash_oe_n && !flash_ce_n && flash_we_n && psram_ce_n && address_latch_n && flash_reset_n) [*7] ##1 flash_oe_n;
    endsequence
    // psram data drivers must stay off for the whole write so the bus can turn round
    sequence psram_write_s;
        (!psram_we_n && !psram_ce_n && psram_oe_n && psram_dq_oe == 2'b00) [*7] ##1 psram_we_n;
    endsequence
    a_psram_idle_quiet: assert property (psram_ce_n |-> psram_dq_oe == 2'b00)
        else $error("psram drives while deselected");
    a_upper_lane_gate: assert property (psram_dq_oe[1] |-> !upper_byte_enable_n && !psram_oe_n)
        else $error("upper lane driven without enable");
    a_lower_lane_gate: assert property (psram_dq_oe[0] |-> !lower_byte_enable_n && !psram_oe_n)
        else $error("lower lane driven without enable");
    a_flash_read_pins: assert property ($fell(flash_oe_n) |-> flash_read_s)
        else $error("flash read pin levels wrong");
    a_psram_write_turn: assert property ($fell(psram_we_n) |-> psram_write_s)
        else $error("psram write strobe or turnaround wrong");
    a_burst_clk_low: assert property (burst_clk == 1'b0)
        else $error("burst clock not low");
    a_no_die_clash: assert property (contention == 2'b00 && !(!flash_ce_n && !psram_ce_n))
        else $error("two drivers or two dies active");
    a_flash_reset_quiet: assert property (!flash_reset_n |-> !flash_dq_oe && !wait_oe)
        else $error("flash drives during reset");
    a_flash_drive_cond: assert property (flash_dq_oe |-> !flash_ce_n && !flash_oe_n)
        else $error("flash drives while not read");
endmodule

// [sim/testbench.sv]
// Purpose: host and device ends joined, checked against an associative array model
// Assumes: 100 MHz mclk, inputs driven on falling edge
// Notes: wake takes about 1000 cycles, the longest step
`timescale 1ns/1ns
`include "nps_consts.svh"
module testbench;
    import nps_pkg::*;
    logic mclk, rst_n, req, flash_unlock_all, busy, done, flash_locked, flash_wait_polarity;
    logic psram_wr_valid, psram_deep_down;
    nps_op_t req_op;
    logic [23:0] req_addr, flash_rd_addr, flash_cmd_addr, psram_rd_addr, psram_wr_addr;
    logic [15:0] req_data, rd_data, flash_rd_data, psram_rd_data, flash_cmd_data, psram_wr_data;
    logic [15:0] bus_config_register, refresh_config_register;
    logic [1:0] req_byte_n, psram_wr_strobe;
    int arr [int];
    int mdl [int];
    int addrs [$];
    int seed = 32'hea3c78bc;
    int err_count, checks, a, d, w, i;
    nps_bus_if bus ();
    nps_host i_nps_host (.mclk(mclk), .rst_n(rst_n), .bus(bus), .req(req), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data), .req_byte_n(req_byte_n), .busy(busy), .done(done),
        .rd_data(rd_data));
    nps_device i_nps_device (.mclk(mclk), .rst_n(rst_n), .bus(bus), .flash_rd_data(flash_rd_data),
        .flash_unlock_all(flash_unlock_all), .psram_rd_data(psram_rd_data), .flash_rd_addr(flash_rd_addr),
        .flash_cmd_valid(), .flash_cmd_addr(flash_cmd_addr), .flash_cmd_data(flash_cmd_data),
        .flash_locked(flash_locked), .flash_wait_polarity(flash_wait_polarity), .psram_rd_addr(psram_rd_addr),
        .psram_wr_valid(psram_wr_valid), .psram_wr_addr(psram_wr_addr), .psram_wr_data(psram_wr_data),
        .psram_wr_strobe(psram_wr_strobe), .psram_active(), .psram_deep_down(psram_deep_down),
        .bus_config_register(bus_config_register), .refresh_config_register(refresh_config_register));
    nps_props i_nps_props (.mclk(mclk), .rst_n(rst_n), .flash_reset_n(bus.flash_reset_n),
        .flash_ce_n(bus.flash_ce_n), .flash_oe_n(bus.flash_oe_n), .flash_we_n(bus.flash_we_n),
        .psram_ce_n(bus.psram_ce_n), .psram_oe_n(bus.psram_oe_n), .psram_we_n(bus.psram_we_n),
        .upper_byte_enable_n(bus.upper_byte_enable_n), .lower_byte_enable_n(bus.lower_byte_enable_n),
        .address_latch_n(bus.address_latch_n), .burst_clk(bus.burst_clk), .flash_dq_oe(bus.flash_dq_oe),
        .psram_dq_oe(bus.psram_dq_oe), .wait_oe(bus.wait_oe), .contention(bus.contention));
    ////////////////////////////////////////////////////////////////////////////
    // user-side storage behind the device, separate from the checking model
    assign flash_rd_data = ~flash_rd_addr[15:0];
    always @(negedge mclk) psram_rd_data <= 16'(arr.exists(int'(psram_rd_addr)) ? arr[int'(psram_rd_addr)] : 0);
    always @(posedge mclk) begin
        if (psram_wr_valid === 1'b1) begin
            w = arr.exists(int'(psram_wr_addr)) ? arr[int'(psram_wr_addr)] : 0;
            if (psram_wr_strobe[1]) w = (w & 32'h000000ff) | (psram_wr_data & 16'hff00);
            if (psram_wr_strobe[0]) w = (w & 32'h0000ff00) | (psram_wr_data & 16'h00ff);
            arr[int'(psram_wr_addr)] = w;
        end
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic op(input nps_op_t o, input int ad, input int dt, input logic [1:0] b);
        repeat (20) if (busy !== 1'b0) @(negedge mclk);
        req_op = o;
        req_addr = 24'(ad);
        req_data = 16'(dt);
        req_byte_n = b;
        req = 1'b1;
        repeat (20) if (busy !== 1'b1) @(negedge mclk);
        req = 1'b0;
        repeat (11000) if (done !== 1'b1) @(negedge mclk);
        check(done, 1'b1, "no done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #300000;
        err_count++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, req, flash_unlock_all, req_addr, req_data} = '0;
        req_op = op_flash_read;
        req_byte_n = 2'b11;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        check(flash_locked, 1'b1, "locked after reset");
        check(refresh_config_register, `NPS_REFRESH_CFG_RESET, "refresh reset");
        check(bus_config_register, `NPS_BUS_CFG_RESET, "bus cfg reset");
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            a = ($random(seed) & 32'h0000fff0) | i;
            d = $random(seed) & 32'h0000ffff;
            op(op_psram_write, a, d, 2'(i));
            w = mdl.exists(a) ? mdl[a] : 0;
            if (!i[1]) w = (w & 32'h000000ff) | (d & 32'h0000ff00);
            if (!i[0]) w = (w & 32'h0000ff00) | (d & 32'h000000ff);
            mdl[a] = w;
            addrs.push_back(a);
        end
        foreach (addrs[k]) begin
            op(op_psram_read, addrs[k], 0, 2'b00);
            check(rd_data, mdl[addrs[k]], "psram word");
        end
        op(op_psram_read, addrs[0], 0, 2'b01);
        check(rd_data, mdl[addrs[0]] & 32'h0000ff00, "upper only");
        op(op_psram_read, addrs[0], 0, 2'b10);
        check(rd_data, mdl[addrs[0]] & 32'h000000ff, "lower only");
        $display("test psram done");
        a = $random(seed) & 32'h00ffffff;
        op(op_flash_read, a, 0, 2'b11);
        check(rd_data, ~a & 32'h0000ffff, "flash read");
        op(op_flash_latch, 32'h00000123, 0, 2'b11);
        op(op_flash_write, a, 32'h000000c5, 2'b11);
        check(flash_cmd_addr, a, "cmd addr");
        check(flash_cmd_data, 16'h00c5, "cmd data");
        op(op_flash_write, 0, `NPS_SCR_SETUP, 2'b11);
        op(op_flash_write, 32'h00000400, `NPS_SCR_CONFIRM, 2'b11);
        check(flash_wait_polarity, 1'b1, "wait polarity");
        flash_unlock_all = 1'b1;
        @(negedge mclk);
        flash_unlock_all = 1'b0;
        check(flash_locked, 1'b0, "unlock");
        $display("test flash done");
        op(op_cfg_read, 32'h00080000, 0, 2'b00);
        check(rd_data, `NPS_BUS_CFG_RESET, "bus cfg read");
        op(op_cfg_read, 0, 0, 2'b00);
        check(rd_data, `NPS_REFRESH_CFG_RESET, "refresh read");
        d = $random(seed) & 32'h0000ffff;
        op(op_cfg_write, 32'h00080000, d, 2'b11);
        op(op_cfg_write, 32'h00040000, 32'h0000a5a5, 2'b00);
        op(op_cfg_read, 32'h00040000, 0, 2'b00);
        check(rd_data, `NPS_IDENT_VALUE, "ident fixed");
        op(op_cfg_read, 32'h00080000, 0, 2'b00);
        check(rd_data, d, "bus cfg written");
        $display("test config done");
        op(op_cfg_write, 0, 0, 2'b00);
        op(op_psram_sleep, 0, 0, 2'b00);
        check(psram_deep_down, 1'b1, "deep entry");
        op(op_psram_read, addrs[0], 0, 2'b00);
        check(rd_data, 16'h0000, "ignored in deep");
        fork
            op(op_psram_wake, 0, 0, 2'b00);
            begin
                repeat (999) @(negedge mclk);
                check(psram_deep_down, 1'b1, "early exit");
                repeat (2) @(negedge mclk);
                check(psram_deep_down, 1'b0, "no exit");
            end
        join
        @(negedge mclk);
        check(psram_deep_down, 1'b1, "re-entry on rise");
        $display("test power done");
        close_out();
    end
endmodule
